// *** rtl/mwdh_handler.sv ***
// request handler for single write, diagnosis echo and multiple write over a modbus rtu byte stream
// assumes a framer on CLK_SYS delivering bytes and an end-of-frame pulse, a same-clock byte sink
// with ready, and a register store that acknowledges each write and flags out-of-range values
`timescale 1ns/1ps
`include "mwdh_regs.svh"

// Function
// - single write stores value, echoes request
// - diagnosis returns received data unchanged
// - only sub-function zero executes
// - diagnosis response repeats whole request
// - multiple write limited to sixteen registers
// - commit registers in ascending address order
// - no rollback after failing register
// - multi request: start, count, bytes, values
// - multi ack echoes start and count
// - crc-16 appended low byte first
// - even address upper, odd lower half
// - bad count or byte count: 03h
// - start plus count at or past limit: 02h
module mwdh_handler
  import mwdh_pkg::*;
#(
  parameter int DEPTH = 64
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // station address
  input wire logic [7:0] STATION_ADDR,
  // received bytes
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_FRAME_END,
  // response bytes
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  output logic TX_LAST,
  input wire logic TX_READY,
  // register store
  output logic WR_EN,
  output logic [15:0] WR_ADDR,
  output logic [15:0] WR_DATA,
  output logic WR_UPPER,
  input wire logic WR_ACK,
  input wire logic WR_ERR,
  // status
  output logic BUSY,
  output logic FRAME_DROP
);
  import mwdh_pkg::*;

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < `MWDH_MIN_DEPTH || DEPTH > 127) begin : g_depth_check
      $error("mwdh_handler: DEPTH must lie between 41 and 127 for the seven bit frame counter");
    end
  endgenerate

  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      c = c[0] ? ((c >> 1) ^ `MWDH_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  mwdh_state_t state;
  logic [6:0] rx_cnt;
  logic rx_ovf;
  logic [15:0] rx_crc;
  logic [7:0] hdr [0:`MWDH_HDR_BYTES-1];
  logic [AW-1:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] hi_byte;
  logic [4:0] reg_i;
  logic is_multi;
  logic exc;
  logic [7:0] exc_code;
  logic [2:0] tx_len;
  logic [2:0] tx_idx;
  logic [15:0] tx_crc;

  logic [7:0] func;
  logic [15:0] f_addr;
  logic [15:0] f_word;
  logic [7:0] f_bcnt;
  logic addr_hit;
  logic bcast;
  logic crc_ok;
  logic [16:0] end_addr;
  logic rx_store;

  assign func = hdr[1];
  assign f_addr = {hdr[2], hdr[3]};
  assign f_word = {hdr[4], hdr[5]};
  assign f_bcnt = hdr[6];
  assign bcast = (hdr[0] == `MWDH_BCAST_ADDR);
  assign addr_hit = (hdr[0] == STATION_ADDR) || bcast;
  // residue of a good frame including its check bytes is zero
  assign crc_ok = (rx_crc == 16'h0000) && !rx_ovf && (rx_cnt >= `MWDH_MIN_LEN);
  assign end_addr = {1'b0, f_addr} + {1'b0, f_word};
  assign rx_store = (state == ST_RX) && RX_VALID && !rx_ovf;

  mwdh_frame_mem #(
    .WIDTH(8),
    .DEPTH(DEPTH)
  ) u_mem (
    .clk(CLK_SYS),
    .we(rx_store),
    .waddr(rx_cnt[AW-1:0]),
    .wdata(RX_DATA),
    .raddr(rd_addr),
    .rdata(rd_data)
  );

  // receive side: byte count, crc, overflow and header capture
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rx_cnt <= 7'h00;
      rx_ovf <= 1'b0;
      rx_crc <= `MWDH_CRC_INIT;
    end else if (state != ST_RX) begin
      rx_cnt <= 7'h00;
      rx_ovf <= 1'b0;
      rx_crc <= `MWDH_CRC_INIT;
    end else if (state == ST_RX && RX_VALID) begin
      // overlong frames are flagged rather than wrapped, so they are never mistaken for good ones
      if (rx_cnt == 7'(DEPTH)) begin
        rx_ovf <= 1'b1;
      end else begin
        rx_cnt <= rx_cnt + 7'h01;
        rx_crc <= crc_step(rx_crc, RX_DATA);
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      for (int k = 0; k < `MWDH_HDR_BYTES; k++) begin
        hdr[k] <= 8'h00;
      end
    end else if (rx_store && rx_cnt < 7'(`MWDH_HDR_BYTES)) begin
      hdr[rx_cnt[2:0]] <= RX_DATA;
    end
  end

  // decode, commit and response sequencing
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_RX;
      exc <= 1'b0;
      exc_code <= 8'h00;
      is_multi <= 1'b0;
      reg_i <= 5'h00;
      rd_addr <= '0;
      hi_byte <= 8'h00;
      FRAME_DROP <= 1'b0;
    end else begin
      FRAME_DROP <= 1'b0;
      case (state)
        ST_RX: begin
          exc <= 1'b0;
          if (RX_FRAME_END && (rx_cnt != 7'h00 || RX_VALID)) begin
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          reg_i <= 5'h00;
          rd_addr <= AW'(`MWDH_DATA_POS);
          is_multi <= (func == `MWDH_FC_WR_MULTI);
          if (!crc_ok) begin
            // no answer to a corrupted frame
            FRAME_DROP <= 1'b1;
            state <= ST_RX;
          end else if (!addr_hit) begin
            state <= ST_RX;
          end else if (func == `MWDH_FC_WR_SINGLE) begin
            if (rx_cnt != `MWDH_FIXED_LEN) begin
              state <= ST_RX;
            end else if (f_addr >= 16'(`MWDH_ADDR_LIMIT)) begin
              exc <= 1'b1;
              exc_code <= `MWDH_EXC_BAD_ADDR;
              state <= ST_RESP;
            end else begin
              // single write goes straight to the store
              state <= ST_ISSUE;
            end
          end else if (func == `MWDH_FC_DIAG) begin
            if (rx_cnt != `MWDH_FIXED_LEN) begin
              state <= ST_RX;
            end else if (f_addr != `MWDH_SUB_ECHO) begin
              exc <= 1'b1;
              exc_code <= `MWDH_EXC_ILL_FUNC;
              state <= ST_RESP;
            end else begin
              state <= ST_RESP;
            end
          end else if (func == `MWDH_FC_WR_MULTI) begin
            if (rx_cnt < `MWDH_MULTI_HDR) begin
              state <= ST_RX;
            end else if (f_word == 16'h0000 || f_word > `MWDH_MAX_REGS || f_bcnt != {f_word[6:0], 1'b0}) begin
              // count and byte count checked before any write
              exc <= 1'b1;
              exc_code <= `MWDH_EXC_BAD_DATA;
              state <= ST_RESP;
            end else if (end_addr >= `MWDH_ADDR_LIMIT) begin
              exc <= 1'b1;
              exc_code <= `MWDH_EXC_BAD_ADDR;
              state <= ST_RESP;
            end else if (rx_cnt != `MWDH_MULTI_HDR + f_bcnt[6:0]) begin
              exc <= 1'b1;
              exc_code <= `MWDH_EXC_BAD_DATA;
              state <= ST_RESP;
            end else begin
              state <= ST_FETCH_HI;
            end
          end else begin
            exc <= 1'b1;
            exc_code <= `MWDH_EXC_ILL_FUNC;
            state <= ST_RESP;
          end
        end
        ST_FETCH_HI: begin
          // values follow the byte count, upper byte first
          rd_addr <= rd_addr + AW'(1);
          state <= ST_FETCH_LO;
        end
        ST_FETCH_LO: begin
          hi_byte <= rd_data;
          rd_addr <= rd_addr + AW'(1);
          state <= ST_ISSUE;
        end
        ST_ISSUE: begin
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (WR_ACK) begin
            if (WR_ERR) begin
              // earlier commits stay; answer slave error
              exc <= 1'b1;
              exc_code <= `MWDH_EXC_SLAVE;
              state <= ST_RESP;
            end else if (is_multi && 16'(reg_i) + 16'h0001 < f_word) begin
              reg_i <= reg_i + 5'h01;
              state <= ST_FETCH_HI;
            end else begin
              state <= ST_RESP;
            end
          end
        end
        ST_RESP: begin
          // broadcast requests are carried out but never answered
          state <= bcast ? ST_RX : ST_TX;
        end
        ST_TX: begin
          if (TX_VALID && TX_READY && TX_LAST) begin
            state <= ST_RX;
          end
        end
        default: begin
          state <= ST_RX;
        end
      endcase
    end
  end

  // store write request, held until acknowledged
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      WR_EN <= 1'b0;
      WR_ADDR <= 16'h0000;
      WR_DATA <= 16'h0000;
      WR_UPPER <= 1'b0;
    end else if (state == ST_ISSUE) begin
      WR_EN <= 1'b1;
      // start address plus register index, ascending
      WR_ADDR <= is_multi ? f_addr + 16'(reg_i) : f_addr;
      WR_DATA <= is_multi ? {hi_byte, rd_data} : f_word;
      // even address carries the upper half
      WR_UPPER <= is_multi ? ~(f_addr[0] ^ reg_i[0]) : ~f_addr[0];
    end else if (state == ST_WAIT && WR_ACK) begin
      WR_EN <= 1'b0;
    end
  end

  // echo bytes 0..5; exceptions send address, flagged function, code
  function automatic logic [7:0] resp_byte(input logic [2:0] idx, input logic e, input logic [7:0] code,
                                            input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                                            input logic [7:0] b3, input logic [7:0] b4, input logic [7:0] b5);
    logic [7:0] r;
    r = b0;
    case (idx)
      3'h1: r = e ? (b1 | `MWDH_EXC_FLAG) : b1;
      3'h2: r = e ? code : b2;
      3'h3: r = b3;
      3'h4: r = b4;
      3'h5: r = b5;
      default: r = b0;
    endcase
    return r;
  endfunction

  // transmit side
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      TX_VALID <= 1'b0;
      TX_DATA <= 8'h00;
      TX_LAST <= 1'b0;
      tx_len <= 3'h0;
      tx_idx <= 3'h0;
      tx_crc <= `MWDH_CRC_INIT;
    end else if (state == ST_RESP) begin
      tx_len <= exc ? `MWDH_EXC_LEN : `MWDH_ECHO_LEN;
      tx_idx <= 3'h0;
      tx_crc <= `MWDH_CRC_INIT;
    end else if (state == ST_TX && (!TX_VALID || TX_READY)) begin
      if (TX_VALID && TX_LAST) begin
        TX_VALID <= 1'b0;
        TX_LAST <= 1'b0;
      end else if (tx_idx < tx_len) begin
        TX_VALID <= 1'b1;
        TX_DATA <= resp_byte(tx_idx, exc, exc_code, hdr[0], hdr[1], hdr[2], hdr[3], hdr[4], hdr[5]);
        tx_crc <= crc_step(tx_crc, resp_byte(tx_idx, exc, exc_code, hdr[0], hdr[1], hdr[2], hdr[3],
                                             hdr[4], hdr[5]));
        tx_idx <= tx_idx + 3'h1;
      end else if (tx_idx == tx_len) begin
        // low crc byte goes out first
        TX_VALID <= 1'b1;
        TX_DATA <= tx_crc[7:0];
        tx_idx <= tx_idx + 3'h1;
      end else begin
        TX_VALID <= 1'b1;
        TX_DATA <= tx_crc[15:8];
        TX_LAST <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      BUSY <= 1'b0;
    end else begin
      BUSY <= (state != ST_RX);
    end
  end
endmodule

// *** rtl/mwdh_regs.svh ***
// constants of the write and diagnosis handler: function codes, field positions, limits, crc
// assumes nothing beyond being included once by each file that needs it
`ifndef MWDH_REGS_SVH
`define MWDH_REGS_SVH

`define MWDH_FC_WR_SINGLE 8'h06
`define MWDH_FC_DIAG 8'h08
`define MWDH_FC_WR_MULTI 8'h10
`define MWDH_SUB_ECHO 16'h0000
`define MWDH_EXC_FLAG 8'h80
`define MWDH_EXC_ILL_FUNC 8'h01
`define MWDH_EXC_BAD_ADDR 8'h02
`define MWDH_EXC_BAD_DATA 8'h03
`define MWDH_EXC_SLAVE 8'h04
`define MWDH_BCAST_ADDR 8'h00
`define MWDH_MAX_REGS 16'h0010
`define MWDH_ADDR_LIMIT 17'h02000
`define MWDH_FIXED_LEN 7'h08
`define MWDH_MULTI_HDR 7'h09
`define MWDH_MIN_LEN 7'h04
`define MWDH_HDR_BYTES 7
`define MWDH_DATA_POS 7'h07
`define MWDH_ECHO_LEN 3'h6
`define MWDH_EXC_LEN 3'h3
`define MWDH_CRC_INIT 16'hffff
`define MWDH_CRC_POLY 16'ha001
`define MWDH_MIN_DEPTH 41

`endif

// *** rtl/mwdh_pkg.sv ***
// types shared by the write and diagnosis handler
// assumes mwdh_regs.svh supplies the numeric constants
package mwdh_pkg;
  typedef enum logic [2:0] {
    ST_RX,
    ST_CHECK,
    ST_FETCH_HI,
    ST_FETCH_LO,
    ST_ISSUE,
    ST_WAIT,
    ST_RESP,
    ST_TX
  } mwdh_state_t;
endpackage

// *** rtl/mwdh_frame_mem.sv ***
// frame byte store: one write port, one read port with registered read data
// assumes a single clock; contents need no reset
`timescale 1ns/1ps
module mwdh_frame_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  // clock
  input wire logic clk,
  // write side
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // read side
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [0:DEPTH-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule

// *** bench/mwdh_handler_chk.sv ***
// port checker for the write and diagnosis handler
// assumes it is bound to mwdh_handler and sees only its ports
`timescale 1ns/1ps
module mwdh_handler_chk (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // response bytes
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_LAST,
  input wire logic TX_READY,
  // register store
  input wire logic WR_EN,
  input wire logic [15:0] WR_ADDR,
  input wire logic [15:0] WR_DATA,
  input wire logic WR_UPPER,
  input wire logic WR_ACK,
  input wire logic WR_ERR,
  // status
  input wire logic FRAME_DROP
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence s_wr_done;
    WR_EN && WR_ACK && !WR_ERR;
  endsequence
  sequence s_quiet;
    (!TX_VALID && !WR_EN) [*8];
  endsequence
  a_drop_pulse: assert property (FRAME_DROP |=> !FRAME_DROP)
    else $error("drop pulse too long");
  a_drop_silent: assert property (FRAME_DROP |-> s_quiet)
    else $error("dropped frame acted on");
  a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
    else $error("tx byte not held");
  a_tx_last_end: assert property (TX_VALID && TX_READY && TX_LAST |=> !TX_VALID)
    else $error("bytes after last");
  a_wr_hold: assert property (WR_EN && !WR_ACK |=> WR_EN && $stable(WR_ADDR) && $stable(WR_DATA))
    else $error("write not held");
  a_wr_release: assert property (WR_EN && WR_ACK |=> !WR_EN)
    else $error("write not released");
  a_upper_even: assert property (WR_EN |-> WR_UPPER == !WR_ADDR[0])
    else $error("upper flag wrong");
  a_addr_ascend: assert property (s_wr_done ##4 WR_EN |-> WR_ADDR == $past(WR_ADDR, 4) + 16'h0001)
    else $error("address not ascending");
  a_err_stops: assert property (WR_EN && WR_ACK && WR_ERR |=> !WR_EN [*8])
    else $error("write after refusal");
endmodule
bind mwdh_handler mwdh_handler_chk u_chk (.CLK_SYS, .RST_N, .TX_VALID, .TX_DATA, .TX_LAST, .TX_READY, .WR_EN,
  .WR_ADDR, .WR_DATA, .WR_UPPER, .WR_ACK, .WR_ERR, .FRAME_DROP);

// *** bench/mwdh_master_model.sv ***
// behavioural bus master: sends request bytes, collects response bytes
// assumes the bench calls send only while the handler is idle
`timescale 1ns/1ps
module mwdh_master_model (
  // clock
  input wire logic clk,
  // request bytes
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_frame_end,
  // response bytes
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] rq[$];
  initial begin
    rx_valid = 0;
    rx_data = 8'h00;
    rx_frame_end = 0;
    tx_ready = 0;
  end
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  // whole frame, crc low then high
  task automatic send(input logic [7:0] f[$], input bit bad);
    logic [15:0] c;
    c = crc16(f) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    foreach (f[i]) begin
      @(negedge clk) rx_valid = 1;
      rx_data = f[i];
      @(negedge clk) rx_valid = 0;
      // released line shows no stale byte
      rx_data = ~f[i];
    end
    @(negedge clk) rx_frame_end = 1;
    @(negedge clk) rx_frame_end = 0;
  endtask
  // random stalls force the slave to hold bytes
  always @(negedge clk) tx_ready <= ($urandom % 4) != 0;
  always @(posedge clk) if (tx_valid && tx_ready) rq.push_back(tx_data);
endmodule

// *** bench/mwdh_handler_tb_top.sv ***
// self-checking bench for the write and diagnosis handler
// assumes the master model and a behavioural register store around the handler
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module mwdh_handler_tb_top;
  typedef logic [7:0] mwdh_bq_t[$];
  logic clk_sys = 0, rst_n = 0, wr_ack = 0, wr_err = 0;
  logic [7:0] station_addr = 8'h01, rx_data, tx_data;
  logic rx_valid, rx_frame_end, tx_ready, tx_valid, tx_last, wr_en, wr_upper, busy, frame_drop;
  logic [15:0] wr_addr, wr_data;
  logic [31:0] wq[$];
  int err_total = 0, samples_checked = 0, err_at = -1, drops = 0, lasts = 0;
  always #2.5 clk_sys = ~clk_sys;
  mwdh_handler DUT (.CLK_SYS(clk_sys), .RST_N(rst_n), .STATION_ADDR(station_addr), .RX_VALID(rx_valid),
    .RX_DATA(rx_data), .RX_FRAME_END(rx_frame_end), .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_LAST(tx_last),
    .TX_READY(tx_ready), .WR_EN(wr_en), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .WR_UPPER(wr_upper),
    .WR_ACK(wr_ack), .WR_ERR(wr_err), .BUSY(busy), .FRAME_DROP(frame_drop));
  mwdh_master_model mst (.clk(clk_sys), .rx_valid(rx_valid), .rx_data(rx_data), .rx_frame_end(rx_frame_end),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  // store acks after a random wait and refuses write number err_at
  always @(negedge clk_sys) begin
    if (wr_en && !wr_ack && $urandom % 3 == 0) begin
      wr_ack <= 1;
      wr_err <= (wq.size() == err_at);
      wq.push_back({wr_addr, wr_data});
    end else begin
      wr_ack <= 0;
      wr_err <= 0;
    end
  end
  always @(posedge clk_sys) if (frame_drop === 1'b1) drops++;
  always @(posedge clk_sys) if (tx_valid === 1'b1 && tx_ready && tx_last === 1'b1) lasts++;
  task automatic tally_and_finish;
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic void predict(input mwdh_bq_t f, input int e, output mwdh_bq_t r, output logic [31:0] w[$]);
    logic [15:0] a, n;
    logic [7:0] code;
    a = {f[2], f[3]};
    n = {f[4], f[5]};
    code = 8'h00;
    w = {};
    case (f[1])
      8'h06: if (a >= 16'h2000) code = 8'h02;
        else begin
          w.push_back({a, n});
          if (e == 0) code = 8'h04;
        end
      8'h08: if (a != 16'h0000) code = 8'h01;
      8'h10: if (n == 0 || n > 16 || f[6] != 2 * n) code = 8'h03;
        else if (a + n >= 32'h2000) code = 8'h02;
        else if (f.size() != 7 + 2 * n) code = 8'h03;
        else for (int i = 0; i < n && code == 0; i++) begin
          w.push_back({16'(a + i), f[7 + 2 * i], f[8 + 2 * i]});
          if (i == e) code = 8'h04;
        end
      default: code = 8'h01;
    endcase
    if (code == 0) r = f[0:5];
    else r = {f[0], f[1] | 8'h80, code};
    if (f[0] == 8'h00) r.delete();
  endfunction
  function automatic mwdh_bq_t multi(input logic [15:0] st, input logic [15:0] n, input logic [7:0] bc, input int len);
    mwdh_bq_t q;
    q = {8'h04, 8'h10, st[15:8], st[7:0], n[15:8], n[7:0], bc};
    repeat (len) q.push_back(8'($urandom));
    return q;
  endfunction
  task automatic run(input mwdh_bq_t f, input int e, input bit bad);
    mwdh_bq_t r;
    logic [31:0] w[$];
    logic [15:0] c;
    int n, d, l;
    predict(f, e, r, w);
    err_at = e;
    wq.delete();
    mst.rq.delete();
    d = drops;
    l = lasts;
    station_addr = f[0];
    mst.send(f, bad);
    n = 0;
    repeat (4) @(negedge clk_sys);
    while (busy !== 1'b0 && n < 4000) begin
      @(negedge clk_sys);
      n++;
    end
    if (bad) begin
      r.delete();
      w.delete();
    end else if (r.size() > 0) begin
      c = mst.crc16(r);
      r.push_back(c[7:0]);
      r.push_back(c[15:8]);
    end
    `CHK(busy, 1'b0)
    `CHK(drops - d, int'(bad))
    `CHK(lasts - l, int'(r.size() > 0))
    `CHK(mst.rq.size(), r.size())
    foreach (r[i]) `CHK(mst.rq[i], r[i])
    `CHK(wq.size(), w.size())
    foreach (w[i]) `CHK(wq[i], w[i])
  endtask
  initial begin
    logic [15:0] d;
    void'($urandom(32'ha2ad9cd3));
    repeat (8) @(negedge clk_sys);
    rst_n = 1;
    run({8'h02, 8'h06, 8'h02, 8'h4b, 8'h00, 8'h50}, -1, 0);
    repeat (4) begin
      d = 16'($urandom);
      run({8'h03, 8'h08, 8'h00, 8'h00, d[15:8], d[7:0]}, -1, 0);
      run({8'h02, 8'h06, 8'h1f, d[7:0], d[15:8], d[7:0]}, -1, 0);
    end
    run({8'h03, 8'h08, 8'h00, 8'h01, 8'h12, 8'h34}, -1, 0);
    // multi writes start even, both halves
    run(multi(16'h0604, 6, 12, 12), -1, 0);
    run(multi(16'h1fee, 16, 32, 32), -1, 0);
    run(multi(16'h0000, 17, 34, 34), -1, 0);
    run(multi(16'h0000, 0, 0, 0), -1, 0);
    run(multi(16'h0010, 2, 3, 4), -1, 0);
    run(multi(16'h0010, 2, 4, 5), -1, 0);
    run(multi(16'h1ffe, 2, 4, 4), -1, 0);
    run(multi(16'h0100, 4, 8, 8), 2, 0);
    run({8'h03, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, -1, 1);
    run({8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, -1, 0);
    run({8'h02, 8'h06, 8'h20, 8'h00, 8'h00, 8'h01}, -1, 0);
    run({8'h00, 8'h06, 8'h00, 8'h30, 8'hff, 8'hff}, -1, 0);
    run({8'h02, 8'h06, 8'h00, 8'h31, 8'h00, 8'h01}, 0, 0);
    tally_and_finish;
  end
  // a whole run needs some 6 us; over thirty times that means a hang
  initial begin
    #200us;
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish;
  end
endmodule
